/* hdl/pwm12_defs.svh */
// Constants for the cascaded 12-bit PWM generator
`ifndef PWM12_DEFS_SVH
`define PWM12_DEFS_SVH
`define OFS_DUTY_LOW 8'h28
`define OFS_DUTY_HIGH 8'h29
`define OFS_MODE 8'h2a
`define OFS_CTRL 8'h2b
`define OFS_STATUS 8'h2c
`define RST_DUTY 8'hff
`define RST_MODE 8'h00
`define MODE_PWM12 2'h2
`define MODE_TFF_BIT 0
`define MODE_DBE_BIT 1
`define MODE_EIN_BIT 2
`define MODE_TCM_LSB 3
`define MODE_TCK_LSB 5
`define CTRL_RUN_BIT 0
`define CTRL_CAS_BIT 1
`define FRAME_LAST 4'hf
`endif

/* hdl/pwm12_pkg.sv */
// Types shared by the cascaded PWM generator
package pwm12_pkg;
  typedef struct packed {
    logic [2:0] clk_sel;
    logic [1:0] high_mode_sel;
    logic ext_sel;
    logic dbuf_enable;
    logic out_initial_level;
  } mode_t;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } duty_pair_t;
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} run_state_t;
endpackage

/* hdl/tick_source.sv */
// Source clock tick generator: prescaler or external count input
`timescale 1ns/1ps
module tick_source #(
  parameter int DIV_W = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic ext_sel,
  input wire logic [2:0] clk_sel,
  input wire logic ext_count_in,
  // Tick
  output logic tick
);
  logic [DIV_W-1:0] pre_ff; // Free prescaler
  logic [DIV_W-1:0] nxt_pre;
  logic ext_d_ff; // Previous external level
  logic nxt_ext_d;
  logic tick_int;
  logic fall;
  int sh;

  // Select divider tap; external input counts falling edges
  always_comb
  begin
    nxt_pre = enable ? pre_ff + 1'b1 : '0;
    nxt_ext_d = ext_count_in;
    fall = ext_d_ff && !ext_count_in;
    case (clk_sel)
      3'h0: sh = 11;
      3'h1: sh = 10;
      3'h2: sh = 8;
      3'h3: sh = 6;
      3'h4: sh = 4;
      3'h5: sh = 2;
      3'h6: sh = 1;
      default: sh = 0;
    endcase
    if (ext_sel)
      tick_int = fall;
    else if (sh == 0)
      tick_int = 1'b1;
    else
      tick_int = (pre_ff[sh-1 -: 1] == 1'b1) &&
        ((pre_ff & ((DIV_W'(1) << sh) - DIV_W'(1))) ==
        ((DIV_W'(1) << sh) - DIV_W'(1)));
    tick = enable && tick_int;
  end

  // Register prescaler and edge detector
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pre_ff <= '0;
      ext_d_ff <= 1'b0;
    end
    else
    begin
      pre_ff <= nxt_pre;
      ext_d_ff <= nxt_ext_d;
    end
  end
endmodule // tick_source

/* hdl/pwm12_core.sv */
// Cascaded timer pair run as a near-12-bit PWM generator
`timescale 1ns/1ps
`include "pwm12_defs.svh"
module pwm12_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Count input and pin
  input wire logic ext_count_in,
  output logic pwm_out_n,
  // Event pulses
  output logic overflow_irq,
  output logic frame_irq
);
  pwm12_pkg::mode_t mode_ff; // Mode register
  pwm12_pkg::mode_t nxt_mode;
  logic run_ff; // Run bit
  logic nxt_run;
  logic cas_ff; // Cascade select bit
  logic nxt_cas;
  pwm12_pkg::duty_pair_t buf_ff; // Software-visible duty pair
  pwm12_pkg::duty_pair_t nxt_buf;
  logic [7:0] low_hold_ff; // Low byte waiting for high write
  logic [7:0] nxt_low_hold;
  logic [11:0] act_ff; // Active duty word used for compare
  logic [11:0] nxt_act;
  logic [7:0] cnt_ff; // Up counter, lower 8 bits
  logic [7:0] nxt_cnt;
  logic [3:0] frame_ff; // Cycle index in frame, 0 means cycle 1
  logic [3:0] nxt_frame;
  logic pend_ff; // Buffered value awaiting frame end
  logic nxt_pend;
  logic out_ff; // Pin level
  logic nxt_out;
  logic ovf_ff;
  logic nxt_ovf;
  logic frm_ff;
  logic nxt_frm;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  pwm12_pkg::run_state_t st_ff;
  pwm12_pkg::run_state_t nxt_st;
  logic active;
  logic tick;
  logic extend;
  logic [8:0] match_at;
  logic wrap;
  logic [11:0] new_word;
  logic high_wr;
  logic [4:0] cyc;

  // Mode is valid only when cascaded and mode field selects PWM
  assign active = run_ff && cas_ff &&
    (mode_ff.high_mode_sel == `MODE_PWM12);

  tick_source u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .enable(active),
    .ext_sel(mode_ff.ext_sel),
    .clk_sel(mode_ff.clk_sel),
    .ext_count_in(ext_count_in),
    .tick(tick)
  );

  // Extension choice for the current cycle, cycle number 1..16
  always_comb
  begin
    cyc = {1'b0, frame_ff} + 5'h01;
    extend = 1'b0;
    if (cyc == 5'h09)
      extend = act_ff[0];
    else if (cyc == 5'h05 || cyc == 5'h0d)
      extend = act_ff[1];
    else if (cyc[1:0] == 2'b11)
      extend = act_ff[2];
    else if (cyc[0] == 1'b0)
      extend = act_ff[3];
    // All-zero selector leaves extend low everywhere
    match_at = {1'b0, act_ff[11:4]} + {8'h00, extend};
  end

  // Register writes, duty staging and the counter datapath
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_run = run_ff;
    nxt_cas = cas_ff;
    nxt_buf = buf_ff;
    nxt_low_hold = low_hold_ff;
    nxt_act = act_ff;
    nxt_pend = pend_ff;
    nxt_cnt = cnt_ff;
    nxt_frame = frame_ff;
    nxt_out = out_ff;
    nxt_ovf = 1'b0;
    nxt_frm = 1'b0;
    nxt_st = st_ff;
    nxt_rdata = 8'h00;
    high_wr = wr && addr == `OFS_DUTY_HIGH;
    new_word = {wdata[3:0], low_hold_ff};
    wrap = 1'b0;
    // Mode writes are ignored once running
    if (wr && addr == `OFS_MODE && !run_ff)
      nxt_mode = pwm12_pkg::mode_t'(wdata);
    if (wr && addr == `OFS_CTRL)
    begin
      nxt_run = wdata[`CTRL_RUN_BIT];
      nxt_cas = wdata[`CTRL_CAS_BIT];
    end
    if (wr && addr == `OFS_DUTY_LOW)
      nxt_low_hold = wdata; // Held until the high byte lands
    if (high_wr)
    begin
      nxt_buf.high = wdata; // Upper nibble kept for readback
      nxt_buf.low = low_hold_ff;
      if (!active || !mode_ff.dbuf_enable)
        nxt_act = new_word;
      else
        nxt_pend = 1'b1;
    end
    case (st_ff)
      pwm12_pkg::ST_IDLE:
      begin
        nxt_cnt = 8'h00;
        nxt_frame = 4'h0;
        nxt_out = mode_ff.out_initial_level;
        if (active)
          nxt_st = pwm12_pkg::ST_RUN;
      end
      pwm12_pkg::ST_RUN:
      begin
        if (!active)
        begin
          // Stop: clear count and index, restore idle level
          nxt_st = pwm12_pkg::ST_IDLE;
          nxt_cnt = 8'h00;
          nxt_frame = 4'h0;
          nxt_out = mode_ff.out_initial_level;
          nxt_pend = 1'b0;
        end
        else
        begin
          // A write equal to the count matches without a tick
          if ({1'b0, cnt_ff} == match_at &&
              out_ff == mode_ff.out_initial_level)
            nxt_out = ~mode_ff.out_initial_level;
          if (tick)
          begin
            nxt_cnt = cnt_ff + 8'h01;
            wrap = cnt_ff == 8'hff;
            if (wrap)
            begin
              nxt_out = mode_ff.out_initial_level;
              nxt_ovf = 1'b1;
              nxt_frame = frame_ff + 4'h1;
              if (frame_ff == `FRAME_LAST)
              begin
                nxt_frm = 1'b1;
                if (pend_ff && !high_wr)
                begin
                  nxt_act = {buf_ff.high[3:0], buf_ff.low};
                  nxt_pend = 1'b0;
                end
              end
            end
          end
        end
      end
      default: nxt_st = pwm12_pkg::ST_IDLE;
    endcase
    // Reads return the stored buffer, never the active word
    if (rd)
    begin
      case (addr)
        `OFS_DUTY_LOW: nxt_rdata = buf_ff.low;
        `OFS_DUTY_HIGH: nxt_rdata = buf_ff.high;
        `OFS_MODE: nxt_rdata = mode_ff;
        `OFS_CTRL: nxt_rdata = {6'h00, cas_ff, run_ff};
        `OFS_STATUS: nxt_rdata = {frame_ff, 3'h0, out_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_ff <= pwm12_pkg::mode_t'(`RST_MODE);
      run_ff <= 1'b0;
      cas_ff <= 1'b0;
      buf_ff <= {`RST_DUTY, `RST_DUTY};
      low_hold_ff <= `RST_DUTY;
      act_ff <= 12'hfff;
      pend_ff <= 1'b0;
      cnt_ff <= 8'h00;
      frame_ff <= 4'h0;
      out_ff <= 1'b0;
      ovf_ff <= 1'b0;
      frm_ff <= 1'b0;
      rdata_ff <= 8'h00;
      st_ff <= pwm12_pkg::ST_IDLE;
    end
    else
    begin
      mode_ff <= nxt_mode;
      run_ff <= nxt_run;
      cas_ff <= nxt_cas;
      buf_ff <= nxt_buf;
      low_hold_ff <= nxt_low_hold;
      act_ff <= nxt_act;
      pend_ff <= nxt_pend;
      cnt_ff <= nxt_cnt;
      frame_ff <= nxt_frame;
      out_ff <= nxt_out;
      ovf_ff <= nxt_ovf;
      frm_ff <= nxt_frm;
      rdata_ff <= nxt_rdata;
      st_ff <= nxt_st;
    end
  end

  assign pwm_out_n = out_ff;
  assign overflow_irq = ovf_ff;
  assign frame_irq = frm_ff;
  assign rdata = rdata_ff;

  // Checks
  a_idle_level: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_ff == pwm12_pkg::ST_IDLE && !active |=>
    out_ff == $past(mode_ff.out_initial_level))
    else $error("idle level wrong");
  a_ovf_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_ff == pwm12_pkg::ST_RUN && active && tick && cnt_ff == 8'hff |=>
    cnt_ff == 8'h00 && ovf_ff && out_ff == mode_ff.out_initial_level)
    else $error("overflow handling wrong");
  a_ovf_pulse: assert property (
    @(posedge clk) disable iff (!rst_n)
    ovf_ff |=> !ovf_ff)
    else $error("overflow pulse too long");
  a_frame_irq: assert property (
    @(posedge clk) disable iff (!rst_n)
    frm_ff |-> ovf_ff && frame_ff == 4'h0)
    else $error("frame pulse not at 16th overflow");
  a_stop_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_ff == pwm12_pkg::ST_RUN && !active |=>
    cnt_ff == 8'h00 && frame_ff == 4'h0)
    else $error("stop did not clear");
  a_count_step: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_ff == pwm12_pkg::ST_RUN && active && tick |=>
    cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("counter did not step");
  a_buf_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    active && mode_ff.dbuf_enable && high_wr && st_ff == pwm12_pkg::ST_RUN
    && !(tick && cnt_ff == 8'hff) |=> act_ff == $past(act_ff))
    else $error("buffered write hit active value");
  a_direct_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    high_wr && (!active || !mode_ff.dbuf_enable) |=>
    act_ff == {$past(wdata[3:0]), $past(low_hold_ff)})
    else $error("direct duty load missing");
  a_match_edge: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_ff == pwm12_pkg::ST_RUN && active && !tick &&
    {1'b0, cnt_ff} == match_at |=>
    out_ff != mode_ff.out_initial_level)
    else $error("no inversion on match");
endmodule // pwm12_core

/* dv/pin_load.sv */
// Far-side model: source of the external count input
`timescale 1ns/1ps
module pin_load (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control from the bench
  input wire logic ext_run,
  // Count input toward the block
  output logic ext_count_in
);
  int ph_ff; // Clocks spent in the current phase
  // Phases of two clocks, the narrowest legal width; idles high
  always_ff @(posedge clk)
  begin
    if (!rst_n || !ext_run)
    begin
      ph_ff <= 0;
      ext_count_in <= 1'b1;
    end
    else if (ph_ff == 1)
    begin
      ph_ff <= 0;
      ext_count_in <= ~ext_count_in;
    end
    else
      ph_ff <= ph_ff + 1;
  end
endmodule // pin_load

/* dv/tb_top.sv */
// Testbench for the cascaded PWM generator
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, wr, rd, ext_run;
  logic [7:0] addr, wdata, rdata;
  logic ext_count_in, pwm_out_n, overflow_irq, frame_irq;
  int fails, checks_done, ovf, n;
  pwm12_core uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ext_count_in(ext_count_in),
    .pwm_out_n(pwm_out_n), .overflow_irq(overflow_irq),
    .frame_irq(frame_irq));
  pin_load far (.clk(clk), .rst_n(rst_n), .ext_run(ext_run),
    .ext_count_in(ext_count_in));
  // 50 ns clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One-cycle write strobe; a gap cycle follows
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(string nm, logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(nm, rdata, exp);
  endtask
  // Low byte first, the high write commits both
  task automatic set_duty(logic [11:0] v);
    wr_reg(8'h28, v[7:0]);
    wr_reg(8'h29, {4'h0, v[11:8]});
  endtask
  // Frame cycles 1..16 that the selector lengthens
  function automatic int ext(logic [3:0] s, int c);
    return (s[0] && c == 9) || (s[1] && c % 8 == 5) ||
      (s[2] && c % 4 == 3) || (s[3] && c % 2 == 0);
  endfunction
  // Counts clocks up to the next overflow pulse, bounded
  task automatic period(logic init, output int len, output int cnt);
    len = 0;
    cnt = 0;
    do
    begin
      cnt += int'(pwm_out_n === init);
      len++;
      @(negedge clk);
    end
    while (overflow_irq !== 1'b1 && len < 3000);
    if (len >= 3000)
    begin
      fails++;
      $display("[ERR] overflow wait timed out");
      print_verdict;
    end
    ovf++;
    check("frame_irq", frame_irq, 16'(ovf % 16 == 0));
  endtask
  task automatic sync(logic init);
    int l, c;
    @(negedge clk);
    period(init, l, c);
  endtask
  // Checks k whole cycles: length, and first-phase width only when tot is 256
  task automatic meas(int k, logic [11:0] v, logic init, int tot);
    int len, cnt, c;
    repeat (k)
    begin
      c = ovf % 16 + 1;
      period(init, len, cnt);
      check("period", 16'(len), 16'(tot));
      if (tot == 256)
        check("duty", 16'(cnt), 16'(v[11:4] + 1 + ext(v[3:0], c)));
    end
  endtask
  task automatic start(logic [7:0] mode, logic init);
    wr_reg(8'h2a, mode);
    wr_reg(8'h2b, 8'h03);
    ovf = 0;
    sync(init);
  endtask
  task automatic stop(logic init);
    wr_reg(8'h2b, 8'h02);
    repeat (2) @(negedge clk);
    check("pin stopped", pwm_out_n, init);
    rd_chk("status", 8'h2c, {7'h0, init});
  endtask
  initial
  begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ext_run = 1'b0;
    fails = 0;
    checks_done = 0;
    ovf = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("low reset", 8'h28, 8'hff);
    rd_chk("high reset", 8'h29, 8'hff);
    rd_chk("unmapped", 8'h31, 8'h00);
    check("pin reset", pwm_out_n, 1'b0);
    wr_reg(8'h29, 8'ha4);
    rd_chk("high upper", 8'h29, 8'ha4);
    wr_reg(8'h2a, 8'hf1);
    repeat (2) @(negedge clk);
    check("idle level", pwm_out_n, 1'b1);
    // Unbuffered, selector bits 0 and 2, over a whole frame
    set_duty(12'h465);
    start(8'hf0, 1'b0);
    meas(17, 12'h465, 1'b0, 256);
    set_duty(12'h0a3);
    sync(1'b0);
    meas(2, 12'h0a3, 1'b0, 256);
    stop(1'b0);
    // High initial level, selector bits 1 and 3
    set_duty(12'h10a);
    start(8'hf1, 1'b1);
    meas(16, 12'h10a, 1'b1, 256);
    stop(1'b1);
    set_duty(12'h200);
    start(8'hf0, 1'b0);
    meas(3, 12'h200, 1'b0, 256);
    stop(1'b0);
    // Buffered: a running write waits for the frame end
    wr_reg(8'h2a, 8'hf2);
    set_duty(12'h130);
    start(8'hf2, 1'b0);
    meas(2, 12'h130, 1'b0, 256);
    set_duty(12'h280);
    rd_chk("buffer low", 8'h28, 8'h80);
    rd_chk("buffer high", 8'h29, 8'h02);
    sync(1'b0);
    meas(12, 12'h130, 1'b0, 256);
    meas(2, 12'h280, 1'b0, 256);
    stop(1'b0);
    // Without mode 2 or without cascade nothing runs
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(8'h2b, 8'h00);
      wr_reg(8'h2a, i ? 8'hf1 : 8'he1);
      wr_reg(8'h2b, i ? 8'h01 : 8'h03);
      n = 0;
      repeat (300)
      begin
        @(negedge clk);
        n += int'(overflow_irq === 1'b1);
      end
      check("idle overflows", 16'(n), 16'h0000);
      check("idle pin", pwm_out_n, 1'b1);
    end
    // External count input: one count per four clocks
    wr_reg(8'h2b, 8'h00);
    @(posedge clk);
    ext_run <= 1'b1;
    start(8'hf4, 1'b0);
    meas(2, 12'h280, 1'b0, 1024);
    print_verdict;
  end
endmodule // tb_top
